// [rtl/dtl_defs.vh]
// Constants for the dual transmitter laser control supervisor
`ifndef DTL_DEFS_VH
`define DTL_DEFS_VH

// Register offsets
`define DTL_ADDR_STATUS 8'h6e
`define DTL_ADDR_PART_ID 8'h86
`define DTL_ADDR_VERSION 8'h87
`define DTL_ADDR_CONFIG_A 8'h88
`define DTL_ADDR_CONFIG_B 8'h89
`define DTL_ADDR_DIS_CFG 8'h8a
`define DTL_ADDR_SLAVE_SEL 8'h8b
`define DTL_ADDR_ALARM_EN_A 8'hf8
`define DTL_ADDR_ALARM_EN_B 8'hfc

// Status byte fields
`define DTL_ST_SOFT_DIS1 7
`define DTL_ST_SOFT_DIS2 6
`define DTL_ST_RATE_IN 5
`define DTL_ST_GEN_IN 4
`define DTL_ST_RATE_SOFT 3
`define DTL_ST_FAULT 2
`define DTL_ST_NOT_READY 0
`define DTL_ST_WR_MASK 8'hc8

// Config A fields
`define DTL_CA_RATE_INV 0
`define DTL_CA_RATE_SW 1
// Config B fields
`define DTL_CB_GEN_INV 0
`define DTL_CB_GEN_FORCE 1
`define DTL_CB_GEN_FVAL 2
`define DTL_CB_FAULT_LATCH 3
// Disable output config fields, channel one in [2:0], two in [6:4]
`define DTL_DC_FAULT 0
`define DTL_DC_DIS 1
`define DTL_DC_FAST 2
`define DTL_DC_CH2_BASE 4

// Shadowed values before recall
`define DTL_SHADOW_ZERO 8'h00

// Default slave addresses and address bases
`define DTL_DEF_ADDR_ONE 8'ha2
`define DTL_DEF_ADDR_TWO 8'hb2
`define DTL_BASE_ADDR_ONE 8'ha0
`define DTL_BASE_ADDR_TWO 8'hb0

// Lookup table layout
`define DTL_FINE_BASE 8'h80
`define DTL_FINE_LAST 7'h47
`define DTL_COARSE_BASE 8'hf8
`define DTL_COARSE_LAST 4'h7
`define DTL_FINE_TEMP_OFS 10'h02a
`define DTL_COARSE_TEMP_OFS 10'h028
`define DTL_COARSE_BAND 10'h012
`define DTL_OFFSET_SHIFT 2

// Alarm bits that stay unlatched while the disable is stretched
`define DTL_LOW_ALARM_BITS 8'h55

// Timing
`define DTL_CLK_MHZ 100
`define DTL_READY_TIME_US 500
`define DTL_SETTLE_CYCLES 10000

`endif

// [rtl/dtl_lut_mem.v]
// Lookup table memory with registered read data
`timescale 1ns/1ps
module dtl_lut_mem #(
	parameter AW = 10,
	parameter DW = 8
) (
	input wire core_clk,
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [DW-1:0] wr_data,
	input wire [AW-1:0] rd_addr,
	output reg [DW-1:0] rd_data
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge core_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

// [rtl/dtl_supervisor.v]
// Dual transmitter laser control supervisor top level
`timescale 1ns/1ps
`include "dtl_defs.vh"
module dtl_supervisor #(
	parameter CODE_W = 10,
	parameter READY_CYCLES = `DTL_READY_TIME_US * `DTL_CLK_MHZ,
	parameter SETTLE_CYCLES = `DTL_SETTLE_CYCLES,
	parameter [7:0] PART_ID = 8'h5a, // Arbitrary value
	parameter [7:0] SILICON_VERSION = 8'h01 // Arbitrary value
) (
	input wire core_clk,
	input wire rst_b,
	input wire above_analog_level,
	input wire above_digital_level,
	input wire [7:0] nv_config_a,
	input wire [7:0] nv_config_b,
	input wire [7:0] nv_disable_cfg,
	input wire [7:0] nv_slave_sel,
	input wire [7:0] nv_alarm_en_a,
	input wire [7:0] nv_alarm_en_b,
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	output wire [7:0] reg_rdata,
	input wire lut_wr,
	input wire [1:0] lut_sel,
	input wire [7:0] lut_addr,
	input wire [7:0] lut_wdata,
	input wire [15:0] temp_reading,
	input wire temp_valid,
	input wire [3:0] table_mode,
	input wire [4*CODE_W-1:0] manual_code,
	input wire [3:0] rest_at_reference,
	input wire general_input_one,
	input wire rate_select_input,
	input wire fault_input_one,
	input wire fault_input_two,
	input wire disable_input_one,
	input wire disable_input_two,
	input wire [1:0] high_trip,
	input wire [1:0] low_power_trip,
	input wire [7:0] adc_alarm,
	input wire [7:0] adc_warning,
	output wire modulation_out_one,
	output wire modulation_out_two,
	output wire power_loop_out_one,
	output wire power_loop_out_two,
	output wire [3:0] dac_oe,
	output wire laser_off_out_one,
	output wire laser_off_out_two,
	output wire laser_off_oe,
	output wire general_output_one_oe,
	output wire rate_select_output_oe,
	output wire fault_output_oe,
	output wire [1:0] stretched_disable,
	output wire [7:0] slave_addr_one,
	output wire [7:0] slave_addr_two,
	output wire not_ready_flag
);
	localparam ST_IDLE = 2'b00;
	localparam ST_FINE = 2'b01;
	localparam ST_COARSE = 2'b10;
	localparam ST_STORE = 2'b11;

	// Volatile storage clears under reset or digital level loss
	wire vol_clr = ~rst_b | ~above_digital_level;

	reg recalled_q;
	reg analog_q;
	reg [15:0] ready_cnt_q;
	reg not_ready_q;
	reg [7:0] status_q;
	reg [7:0] cfg_a_q;
	reg [7:0] cfg_b_q;
	reg [7:0] dis_cfg_q;
	reg [7:0] slave_sel_q;
	reg [7:0] en_a_q;
	reg [7:0] en_b_q;
	reg [7:0] rdata_q;
	reg [7:0] addr1_q;
	reg [7:0] addr2_q;

	wire analog_ok = above_analog_level;
	wire analog_rise = analog_ok & ~analog_q;
	wire [1:0] dis_any = {disable_input_two | status_q[`DTL_ST_SOFT_DIS2],
		disable_input_one | status_q[`DTL_ST_SOFT_DIS1]};
	reg [1:0] dis_prev_q;

	// Power sequencing and recall
	always @(posedge core_clk) begin
		if (vol_clr) begin
			recalled_q <= 1'b0;
			analog_q <= 1'b0;
			ready_cnt_q <= 16'h0000;
			not_ready_q <= 1'b1;
		end else begin
			analog_q <= analog_ok;
			if (analog_rise) begin
				recalled_q <= 1'b1;
			end
			if (!analog_ok) begin
				ready_cnt_q <= 16'h0000;
				not_ready_q <= 1'b1;
			end else if (ready_cnt_q == READY_CYCLES[15:0] - 16'h0001) begin
				not_ready_q <= 1'b0;
			end else begin
				ready_cnt_q <= ready_cnt_q + 16'h0001;
			end
		end
	end

	wire do_recall = analog_rise & ~recalled_q;

	// Register file
	always @(posedge core_clk) begin
		if (vol_clr) begin
			cfg_a_q <= `DTL_SHADOW_ZERO;
			cfg_b_q <= `DTL_SHADOW_ZERO;
			dis_cfg_q <= `DTL_SHADOW_ZERO;
			slave_sel_q <= `DTL_SHADOW_ZERO;
			en_a_q <= `DTL_SHADOW_ZERO;
			en_b_q <= `DTL_SHADOW_ZERO;
			status_q <= 8'h00;
		end else if (do_recall) begin
			cfg_a_q <= nv_config_a;
			cfg_b_q <= nv_config_b;
			dis_cfg_q <= nv_disable_cfg;
			slave_sel_q <= nv_slave_sel;
			en_a_q <= nv_alarm_en_a;
			en_b_q <= nv_alarm_en_b;
		end else if (reg_wr) begin
			case (reg_addr)
			`DTL_ADDR_STATUS: begin
				status_q <= reg_wdata & `DTL_ST_WR_MASK;
			end
			`DTL_ADDR_CONFIG_A: begin
				cfg_a_q <= reg_wdata;
			end
			`DTL_ADDR_CONFIG_B: begin
				cfg_b_q <= reg_wdata;
			end
			`DTL_ADDR_DIS_CFG: begin
				dis_cfg_q <= reg_wdata;
			end
			`DTL_ADDR_SLAVE_SEL: begin
				slave_sel_q <= reg_wdata;
			end
			`DTL_ADDR_ALARM_EN_A: begin
				en_a_q <= reg_wdata;
			end
			`DTL_ADDR_ALARM_EN_B: begin
				en_b_q <= reg_wdata;
			end
			default: begin
			end
			endcase
		end
	end

	reg fault_q;
	reg [7:0] status_view;
	always @* begin
		status_view = status_q;
		status_view[`DTL_ST_RATE_IN] = rate_select_input;
		status_view[`DTL_ST_GEN_IN] = general_input_one;
		status_view[`DTL_ST_FAULT] = fault_q;
		status_view[`DTL_ST_NOT_READY] = not_ready_q;
	end

	always @(posedge core_clk) begin
		if (vol_clr) begin
			rdata_q <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
			`DTL_ADDR_STATUS: rdata_q <= status_view;
			`DTL_ADDR_PART_ID: rdata_q <= PART_ID;
			`DTL_ADDR_VERSION: rdata_q <= SILICON_VERSION;
			`DTL_ADDR_CONFIG_A: rdata_q <= cfg_a_q;
			`DTL_ADDR_CONFIG_B: rdata_q <= cfg_b_q;
			`DTL_ADDR_DIS_CFG: rdata_q <= dis_cfg_q;
			`DTL_ADDR_SLAVE_SEL: rdata_q <= slave_sel_q;
			`DTL_ADDR_ALARM_EN_A: rdata_q <= en_a_q;
			`DTL_ADDR_ALARM_EN_B: rdata_q <= en_b_q;
			default: rdata_q <= 8'h00;
			endcase
		end
	end

	// Active slave addresses
	always @(posedge core_clk) begin
		if (vol_clr || !recalled_q) begin
			addr1_q <= `DTL_DEF_ADDR_ONE;
			addr2_q <= `DTL_DEF_ADDR_TWO;
		end else begin
			addr1_q <= `DTL_BASE_ADDR_ONE | {4'h0, slave_sel_q[2:0], 1'b0};
			addr2_q <= `DTL_BASE_ADDR_TWO | {4'h0, slave_sel_q[2:0], 1'b0};
		end
	end

	// Temperature and table indices
	reg [7:0] temp_q;
	reg [7:0] fine_idx;
	reg [7:0] coarse_idx;
	reg [9:0] tf;
	reg [9:0] tc;
	reg [9:0] band;
	always @* begin
		tf = {{2{temp_q[7]}}, temp_q} + `DTL_FINE_TEMP_OFS;
		tc = {{2{temp_q[7]}}, temp_q} + `DTL_COARSE_TEMP_OFS;
		band = tc / `DTL_COARSE_BAND;
		if (tf[9]) begin
			fine_idx = `DTL_FINE_BASE;
		end else if (tf[9:1] > {2'b00, `DTL_FINE_LAST}) begin
			fine_idx = `DTL_FINE_BASE + {1'b0, `DTL_FINE_LAST};
		end else begin
			fine_idx = `DTL_FINE_BASE + tf[8:1];
		end
		if (tc[9]) begin
			coarse_idx = `DTL_COARSE_BASE;
		end else if (band > {6'h00, `DTL_COARSE_LAST}) begin
			coarse_idx = `DTL_COARSE_BASE + {4'h0, `DTL_COARSE_LAST};
		end else begin
			coarse_idx = `DTL_COARSE_BASE + band[7:0];
		end
	end

	// Table fetch sequencer
	reg [1:0] state_q;
	reg [1:0] ch_q;
	reg pend_q;
	reg [7:0] fine_q;
	reg [4*CODE_W-1:0] code_q;
	wire [7:0] mem_rd;
	wire [1:0] dis_rel = dis_prev_q & ~dis_any;
	wire upd_req = temp_valid | (|dis_rel);
	wire start = (state_q == ST_IDLE) & pend_q;
	wire [9:0] mem_raddr = {ch_q, (state_q == ST_FINE) ? fine_idx : coarse_idx};
	wire [CODE_W-1:0] tbl_code = {{(CODE_W-8){1'b0}}, fine_q} +
		{{(CODE_W-10){1'b0}}, mem_rd, 2'b00};

	always @(posedge core_clk) begin
		if (vol_clr) begin
			state_q <= ST_IDLE;
			ch_q <= 2'b00;
			pend_q <= 1'b0;
			fine_q <= 8'h00;
			code_q <= {(4*CODE_W){1'b0}};
			temp_q <= 8'h00;
			dis_prev_q <= 2'b00;
		end else begin
			dis_prev_q <= dis_any;
			if (temp_valid) begin
				temp_q <= temp_reading[15:8];
			end
			// New request wins over the start that clears it
			pend_q <= (pend_q & ~start) | upd_req;
			case (state_q)
			ST_IDLE: begin
				if (start) begin
					ch_q <= 2'b00;
					state_q <= ST_FINE;
				end
			end
			ST_FINE: begin
				state_q <= ST_COARSE;
			end
			ST_COARSE: begin
				fine_q <= mem_rd;
				state_q <= ST_STORE;
			end
			ST_STORE: begin
				code_q[ch_q*CODE_W +: CODE_W] <= tbl_code;
				ch_q <= ch_q + 2'b01;
				state_q <= (ch_q == 2'b11) ? ST_IDLE : ST_FINE;
			end
			default: begin
				state_q <= ST_IDLE;
			end
			endcase
		end
	end

	dtl_lut_mem #(
		.AW(10),
		.DW(8)
	) u_lut (
		.core_clk(core_clk),
		.wr_en(lut_wr),
		.wr_addr({lut_sel, lut_addr}),
		.wr_data(lut_wdata),
		.rd_addr(mem_raddr),
		.rd_data(mem_rd)
	);

	// Disable stretch and fast shutdown per transmitter
	reg [1:0] fast_q;
	reg [1:0] stretch_q;
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_tx
			reg [15:0] st_cnt_q;
			always @(posedge core_clk) begin
				if (vol_clr) begin
					st_cnt_q <= 16'h0000;
					stretch_q[g] <= 1'b0;
					fast_q[g] <= 1'b0;
				end else begin
					if (dis_any[g]) begin
						st_cnt_q <= SETTLE_CYCLES[15:0];
					end else if (st_cnt_q != 16'h0000) begin
						st_cnt_q <= st_cnt_q - 16'h0001;
					end
					stretch_q[g] <= dis_any[g] | (st_cnt_q > 16'h0001);
					fast_q[g] <= high_trip[g] |
						(low_power_trip[g] & ~stretch_q[g]);
				end
			end
		end
	endgenerate

	// Delta-sigma outputs: ch0 mod one, ch1 mod two, ch2 loop one, ch3 two
	reg [3:0] pdm_q;
	reg [3:0] dac_oe_q;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_dac
			reg [CODE_W-1:0] acc_q;
			wire [CODE_W-1:0] eff = table_mode[g] ?
				code_q[g*CODE_W +: CODE_W] :
				manual_code[g*CODE_W +: CODE_W];
			wire [CODE_W:0] sum = {1'b0, acc_q} + {1'b0, eff};
			wire off = ~analog_ok | dis_any[g%2] | fast_q[g%2];
			always @(posedge core_clk) begin
				if (vol_clr) begin
					acc_q <= {CODE_W{1'b0}};
					pdm_q[g] <= 1'b0;
					dac_oe_q[g] <= 1'b0;
				end else begin
					acc_q <= sum[CODE_W-1:0];
					pdm_q[g] <= off ? rest_at_reference[g] : sum[CODE_W];
					dac_oe_q[g] <= analog_ok & ~not_ready_q;
				end
			end
		end
	endgenerate

	// Laser-off, general, rate-select and fault outputs
	reg lo1_q;
	reg lo2_q;
	reg lo_oe_q;
	reg gen_oe_q;
	reg rate_oe_q;
	reg fault_oe_q;
	reg latch_q;
	wire [2:0] dc1 = dis_cfg_q[2:0];
	wire [2:0] dc2 = dis_cfg_q[`DTL_DC_CH2_BASE +: 3];
	wire [7:0] gated = (adc_alarm & en_a_q) | (adc_warning & en_b_q);
	wire [7:0] low_keep = (|stretch_q) ? ~`DTL_LOW_ALARM_BITS : 8'hff;
	wire trips = |high_trip | |(low_power_trip & ~stretch_q);
	wire latchable = |(gated & low_keep) | trips | fault_input_one |
		fault_input_two;
	wire fault_now = |gated | |high_trip | |low_power_trip | |dis_any |
		fault_input_one | fault_input_two;
	wire gen_src = cfg_b_q[`DTL_CB_GEN_FORCE] ?
		cfg_b_q[`DTL_CB_GEN_FVAL] : general_input_one;
	wire rate_src = cfg_a_q[`DTL_CA_RATE_SW] ?
		status_q[`DTL_ST_RATE_SOFT] : rate_select_input;
	wire dis_rise = |(dis_any & ~dis_prev_q);

	always @(posedge core_clk) begin
		if (vol_clr) begin
			lo1_q <= 1'b0;
			lo2_q <= 1'b0;
			lo_oe_q <= 1'b0;
			gen_oe_q <= 1'b0;
			rate_oe_q <= 1'b0;
			fault_oe_q <= 1'b0;
			latch_q <= 1'b0;
			fault_q <= 1'b0;
		end else begin
			lo1_q <= (dc1[`DTL_DC_FAULT] & fault_input_one) |
				(dc1[`DTL_DC_DIS] & dis_any[0]) |
				(dc1[`DTL_DC_FAST] & fast_q[0]);
			lo2_q <= (dc2[`DTL_DC_FAULT] & fault_input_two) |
				(dc2[`DTL_DC_DIS] & dis_any[1]) |
				(dc2[`DTL_DC_FAST] & fast_q[1]);
			lo_oe_q <= analog_ok;
			// Open-drain pins pull low when the level is zero
			gen_oe_q <= analog_ok &
				~(gen_src ^ cfg_b_q[`DTL_CB_GEN_INV]);
			rate_oe_q <= analog_ok &
				~(rate_src ^ cfg_a_q[`DTL_CA_RATE_INV]);
			// Latched faults clear on a new disable; a new fault wins
			if (cfg_b_q[`DTL_CB_FAULT_LATCH]) begin
				latch_q <= (latch_q & ~dis_rise) | latchable;
			end else begin
				latch_q <= 1'b0;
			end
			fault_q <= fault_now | latch_q;
			fault_oe_q <= analog_ok & ~(fault_now | latch_q);
		end
	end

	assign reg_rdata = rdata_q;
	assign modulation_out_one = pdm_q[0];
	assign modulation_out_two = pdm_q[1];
	assign power_loop_out_one = pdm_q[2];
	assign power_loop_out_two = pdm_q[3];
	assign dac_oe = dac_oe_q;
	assign laser_off_out_one = lo1_q;
	assign laser_off_out_two = lo2_q;
	assign laser_off_oe = lo_oe_q;
	assign general_output_one_oe = gen_oe_q;
	assign rate_select_output_oe = rate_oe_q;
	assign fault_output_oe = fault_oe_q;
	assign stretched_disable = stretch_q;
	assign slave_addr_one = addr1_q;
	assign slave_addr_two = addr2_q;
	assign not_ready_flag = not_ready_q;
endmodule

// [test/dtl_supervisor_properties.sv]
// Concurrent checks on the supervisor top level ports
`timescale 1ns/1ps
module dtl_supervisor_props #(
	parameter READY_CYCLES = 50000,
	parameter SETTLE_CYCLES = 10000
) (
	input wire core_clk,
	input wire rst_b,
	input wire above_analog_level,
	input wire above_digital_level,
	input wire [7:0] nv_slave_sel,
	input wire disable_input_one,
	input wire not_ready_flag,
	input wire [3:0] dac_oe,
	input wire laser_off_oe,
	input wire general_output_one_oe,
	input wire rate_select_output_oe,
	input wire fault_output_oe,
	input wire [1:0] stretched_disable,
	input wire [7:0] slave_addr_one,
	input wire [7:0] slave_addr_two
);
	logic [15:0] hi_cnt_q;
	logic rec_q;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	// Cycles of unbroken analog supply
	always @(posedge core_clk) begin
		if (!rst_b || !above_digital_level || !above_analog_level)
			hi_cnt_q <= 16'h0000;
		else if (hi_cnt_q != 16'hffff)
			hi_cnt_q <= hi_cnt_q + 16'h0001;
	end
	always @(posedge core_clk) begin
		if (!rst_b || !above_digital_level)
			rec_q <= 1'b0;
		else if (above_analog_level)
			rec_q <= 1'b1;
	end
	property p_ready_back;
		!above_analog_level |=> not_ready_flag;
	endproperty
	a_ready_back: assert property (p_ready_back)
		else $error("ready flag not set below analog level");
	property p_ready_early;
		hi_cnt_q > 0 && hi_cnt_q < READY_CYCLES - 1 |-> not_ready_flag;
	endproperty
	a_ready_early: assert property (p_ready_early)
		else $error("ready flag cleared too early");
	property p_ready_late;
		hi_cnt_q > READY_CYCLES + 1 |-> !not_ready_flag;
	endproperty
	a_ready_late: assert property (p_ready_late)
		else $error("ready flag cleared too late");
	property p_dac_off;
		not_ready_flag [*2] |-> dac_oe == 4'h0;
	endproperty
	a_dac_off: assert property (p_dac_off)
		else $error("modulated outputs driven before ready");
	property p_dac_on;
		(above_analog_level && !not_ready_flag) [*2] |-> dac_oe == 4'hf;
	endproperty
	a_dac_on: assert property (p_dac_on)
		else $error("modulated outputs not driven when ready");
	property p_laser_float;
		!above_analog_level |=> !laser_off_oe;
	endproperty
	a_laser_float: assert property (p_laser_float)
		else $error("laser off pins driven below analog level");
	property p_laser_back;
		above_analog_level && above_digital_level |=> laser_off_oe;
	endproperty
	a_laser_back: assert property (p_laser_back)
		else $error("laser off pins not resumed");
	property p_od_off;
		!above_analog_level |=> !(general_output_one_oe ||
			rate_select_output_oe || fault_output_oe);
	endproperty
	a_od_off: assert property (p_od_off)
		else $error("open drain pin pulled below analog level");
	property p_addr_def;
		!above_digital_level |=>
			slave_addr_one == 8'ha2 && slave_addr_two == 8'hb2;
	endproperty
	a_addr_def: assert property (p_addr_def)
		else $error("slave address not at default");
	property p_recall;
		$rose(above_analog_level) && !rec_q && above_digital_level |-> ##2
			slave_addr_one == {4'ha, $past(nv_slave_sel[2:0], 2), 1'b0} &&
			slave_addr_two == {4'hb, $past(nv_slave_sel[2:0], 2), 1'b0};
	endproperty
	a_recall: assert property (p_recall)
		else $error("recalled slave address wrong");
	property p_stretch;
		$fell(disable_input_one) |=> stretched_disable[0] [*8];
	endproperty
	a_stretch: assert property (p_stretch)
		else $error("disable not stretched");
	c_recall: cover property ($rose(above_analog_level) && !rec_q);
	c_stretch: cover property ($fell(stretched_disable[0]));
	c_dac_on: cover property ($rose(dac_oe[0]));
endmodule

bind dtl_supervisor dtl_supervisor_props #(.READY_CYCLES(READY_CYCLES),
	.SETTLE_CYCLES(SETTLE_CYCLES)) u_dtl_supervisor_props (.*);

// [test/dtl_driver_model.sv]
// Laser driver pair and pull-up model at the supervisor pins
`timescale 1ns/1ps
module dtl_driver_model (
	input wire core_clk,
	input wire [1:0] pdm,
	input wire [1:0] pdm_oe,
	input wire [1:0] off_out,
	input wire off_oe,
	input wire [2:0] od_oe,
	input wire cnt_clr,
	input wire cnt_en,
	output logic [1:0] tx_off,
	output logic [2:0] od_pin,
	output logic [10:0] ones_one,
	output logic [10:0] ones_two
);
	// Floating disable input is pulled up, laser stays off
	assign tx_off = off_oe ? off_out : 2'b11;
	assign od_pin = ~od_oe;
	// Filter stand-in: pulse density of driven outputs
	always @(posedge core_clk) begin
		if (cnt_clr) begin
			ones_one <= 11'h000;
			ones_two <= 11'h000;
		end else if (cnt_en) begin
			ones_one <= ones_one + {10'h000, pdm[0] & pdm_oe[0]};
			ones_two <= ones_two + {10'h000, pdm[1] & pdm_oe[1]};
		end
	end
endmodule

// [test/tb_dtl_supervisor.sv]
// Self-checking bench for the laser control supervisor
`timescale 1ns/1ps
module tb_dtl_supervisor;
	localparam RDY = 20;
	localparam STL = 16;
	localparam [7:0] PID = 8'h3c; // Arbitrary value
	localparam [7:0] VER = 8'h07; // Arbitrary value
	logic core_clk = 0, rst_b = 0, above_analog_level = 0;
	logic above_digital_level = 1, cnt_clr = 0, cnt_en = 0;
	logic [7:0] nv_config_a, nv_config_b, nv_disable_cfg, nv_slave_sel;
	logic [7:0] nv_alarm_en_a, nv_alarm_en_b, reg_addr = 0, reg_wdata = 0;
	logic reg_wr = 0, reg_rd = 0, lut_wr = 0, temp_valid = 0;
	logic [1:0] lut_sel = 0, high_trip = 0, low_power_trip = 0;
	logic [7:0] lut_addr = 0, lut_wdata = 0, adc_alarm = 0, adc_warning = 0;
	logic [15:0] temp_reading = 0;
	logic [3:0] table_mode = 0, rest_at_reference = 0, dac_oe;
	logic [39:0] manual_code = 0;
	logic general_input_one = 0, rate_select_input = 0, fault_input_one = 0;
	logic fault_input_two = 0, disable_input_one = 0, disable_input_two = 0;
	logic [7:0] reg_rdata, slave_addr_one, slave_addr_two, rd;
	logic modulation_out_one, modulation_out_two, power_loop_out_one;
	logic power_loop_out_two, laser_off_out_one, laser_off_out_two;
	logic laser_off_oe, general_output_one_oe, rate_select_output_oe;
	logic fault_output_oe, not_ready_flag;
	logic [1:0] stretched_disable, tx_off;
	logic [2:0] od_pin;
	logic [10:0] ones_one, ones_two;
	int miscompares = 0, checked = 0, k;
	// Write flag, address, data, expected read
	logic [24:0] rows [13] = '{25'h086003c, 25'h0870007, 25'h0880002,
		25'h0890000, 25'h08a0002, 25'h08b0003, 25'h0f80011, 25'h0fc0022,
		25'h0500000, 25'h186ff3c, 25'h150ff00, 25'h1f85a5a, 25'h1fca5a5};
	dtl_supervisor #(.READY_CYCLES(RDY), .SETTLE_CYCLES(STL), .PART_ID(PID),
		.SILICON_VERSION(VER)) u_dtl_supervisor (.*);
	dtl_driver_model u_dtl_driver_model (.core_clk(core_clk),
		.pdm({modulation_out_two, modulation_out_one}), .pdm_oe(dac_oe[1:0]),
		.off_out({laser_off_out_two, laser_off_out_one}), .off_oe(laser_off_oe),
		.od_oe({fault_output_oe, rate_select_output_oe, general_output_one_oe}),
		.cnt_clr(cnt_clr), .cnt_en(cnt_en), .tx_off(tx_off), .od_pin(od_pin),
		.ones_one(ones_one), .ones_two(ones_two));
	always #5 core_clk = ~core_clk;
	task automatic conclude();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] s, e);
		checked++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	function automatic logic near(input logic [10:0] a, input int e);
		return a + 1 >= e && a <= e + 1;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, d);
		cyc(1);
		{reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		cyc(1);
		reg_wr = 0;
	endtask
	task automatic rdr(input logic [7:0] a);
		cyc(1);
		{reg_addr, reg_rd} = {a, 1'b1};
		cyc(1);
		reg_rd = 0;
		rd = reg_rdata;
	endtask
	task automatic lut(input logic [1:0] s, input logic [7:0] a, d);
		cyc(1);
		{lut_sel, lut_addr, lut_wdata, lut_wr} = {s, a, d, 1'b1};
		cyc(1);
		lut_wr = 0;
	endtask
	task automatic meas();
		cnt_clr = 1;
		cyc(1);
		{cnt_clr, cnt_en} = 2'b01;
		cyc(1024);
		cnt_en = 0;
	endtask
	initial begin
		{nv_config_a, nv_config_b, nv_disable_cfg} = 24'h020002;
		{nv_slave_sel, nv_alarm_en_a, nv_alarm_en_b} = 24'h031122;
		cyc(4);
		rst_b = 1;
		chk("not_ready", not_ready_flag, 1);
		chk("addr_one", slave_addr_one, 8'ha2);
		chk("addr_two", slave_addr_two, 8'hb2);
		chk("oe off", {dac_oe, laser_off_oe}, 0);
		chk("od pins", od_pin, 3'h7);
		rdr(8'h88);
		chk("shadow zero", rd, 0);
		above_analog_level = 1;
		cyc(3);
		chk("addr_one", slave_addr_one, 8'ha6);
		chk("addr_two", slave_addr_two, 8'hb6);
		for (k = 0; k < 200 && not_ready_flag !== 1'b0; k++)
			cyc(1);
		chk("ready", not_ready_flag, 0);
		if (not_ready_flag !== 1'b0)
			conclude();
		foreach (rows[i]) begin
			if (rows[i][24])
				wr(rows[i][23:16], rows[i][15:8]);
			rdr(rows[i][23:16]);
			chk("reg", rd, rows[i][7:0]);
		end
		for (k = 0; k < 2; k++) begin
			{rate_select_input, general_input_one} = k ? 2'b01 : 2'b10;
			cyc(3);
			rdr(8'h6e);
			chk("status pins", rd & 8'h30, k ? 8'h10 : 8'h20);
		end
		for (k = 0; k < 8; k++) begin
			general_input_one = k[0];
			wr(8'h89, {5'h00, k[2], k[2], k[1]});
			cyc(3);
			chk("gen pin", od_pin[0], (k[2] | k[0]) ^ k[1]);
		end
		for (k = 0; k < 4; k++) begin
			wr(8'h88, {6'h00, 1'b1, k[1]});
			wr(8'h6e, {4'h0, k[0], 3'h0});
			cyc(3);
			chk("rate pin", od_pin[1], k[0] ^ k[1]);
		end
		// Table code on channel one, manual code on channel two
		lut(0, 8'haa, 8'h7b);
		lut(0, 8'hfc, 8'h2a);
		manual_code = 40'd100 << 10;
		table_mode = 4'h1;
		temp_reading = 16'h2b00;
		temp_valid = 1;
		cyc(1);
		temp_valid = 0;
		cyc(40);
		meas();
		chk("table code", near(ones_one, 291), 1);
		chk("manual code", near(ones_two, 100), 1);
		rest_at_reference = 4'hd;
		disable_input_one = 1;
		cyc(4);
		chk("laser off", tx_off[0], 1);
		chk("loop one rest", power_loop_out_one, 1);
		chk("loop two idle", power_loop_out_two, 0);
		chk("fault pin", od_pin[2], 1);
		meas();
		chk("rest level", ones_one, 1024);
		// Table change hidden until the disable is released
		lut(0, 8'haa, 8'h00);
		disable_input_one = 0;
		cyc(40);
		chk("fault gone", od_pin[2], 0);
		meas();
		chk("reload", near(ones_one, 168), 1);
		wr(8'h6e, 8'h80);
		cyc(4);
		chk("soft off", tx_off[0], 1);
		wr(8'h6e, 8'h00);
		cyc(STL + 4);
		wr(8'h8a, 8'h04);
		disable_input_one = 1;
		cyc(2);
		disable_input_one = 0;
		low_power_trip = 2'b01;
		cyc(4);
		chk("trip masked", tx_off[0], 0);
		high_trip = 2'b01;
		cyc(4);
		chk("high trip", tx_off[0], 1);
		high_trip = 0;
		cyc(STL);
		chk("low trip", tx_off[0], 1);
		low_power_trip = 0;
		// Latched fault, cleared by a new disable
		wr(8'h8a, 8'h20);
		wr(8'h89, 8'h08);
		adc_alarm = 8'h02;
		cyc(2);
		adc_alarm = 0;
		cyc(2);
		chk("fault latched", od_pin[2], 1);
		disable_input_two = 1;
		cyc(4);
		chk("laser off two", {laser_off_out_two, tx_off}, 3'h6);
		// Low warning while stretched must not latch
		disable_input_two = 0;
		adc_warning = 8'h01;
		cyc(2);
		adc_warning = 0;
		cyc(3);
		chk("low not latched", od_pin[2], 0);
		above_analog_level = 0;
		cyc(2);
		chk("brown ready", not_ready_flag, 1);
		chk("brown float", {laser_off_oe, dac_oe}, 0);
		{nv_config_a, nv_config_b, nv_disable_cfg} = 24'h010004;
		{nv_slave_sel, nv_alarm_en_a, nv_alarm_en_b} = 24'h054433;
		above_analog_level = 1;
		cyc(3);
		rdr(8'h88);
		chk("kept cfg", rd, 8'h03);
		above_analog_level = 0;
		above_digital_level = 0;
		cyc(2);
		chk("def addr", slave_addr_one, 8'ha2);
		above_digital_level = 1;
		cyc(2);
		above_analog_level = 1;
		cyc(3);
		rdr(8'h88);
		chk("recall again", rd, 8'h01);
		chk("new addr", slave_addr_one, 8'haa);
		conclude();
	end
endmodule
